// ### design/aes_block_encrypt_unit.sv
// single block aes encryption unit with dma and register port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns

module aes_block_encrypt_unit (
  input  wire logic         clk,
  input  wire logic         reset,
  // register port
  input  wire logic [11:0]  wrAddr,
  input  wire logic [31:0]  wrData,
  input  wire logic         wrEn,
  input  wire logic [11:0]  rdAddr,
  input  wire logic         rdEn,
  output logic      [31:0]  rdData,
  output logic              irq,
  // dma port to data ram
  output logic              memReq,
  output logic              memWrite,
  output logic      [31:0]  memAddr,
  output logic      [31:0]  memWdata,
  input  wire logic [31:0]  memRdata,
  input  wire logic         memAck,
  // shared aes core
  input  wire logic         aesBusy,
  input  wire logic         aesPreempt,
  output logic              aesLoad,
  output logic      [127:0] aesKey,
  output logic      [127:0] aesBlock,
  input  wire logic         aesDone,
  input  wire logic [127:0] aesResult
);

  // ****************************************
  // state
  // ****************************************
  aes_block_encrypt_pkg::state_t state, next_state; // sequencer
  logic [3:0]   idx,      next_idx;       // dma word index
  logic [31:0]  ptr,      next_ptr;       // structure base
  logic         doneEv,   next_doneEv;    // completion flag
  logic         errorEv,  next_errorEv;   // error flag
  logic [1:0]   ien,      next_ien;       // interrupt enables
  logic [31:0]  next_rdData;              // read answer
  logic         next_irq;                 // interrupt line
  logic         next_memReq;              // dma request
  logic         next_memWrite;            // dma direction
  logic [31:0]  next_memAddr;             // dma address
  logic [31:0]  next_memWdata;            // dma write word
  logic         next_aesLoad;             // core load pulse
  logic [127:0] next_aesKey;              // key copy
  logic [127:0] next_aesBlock;            // data block copy
  logic         startHit;                 // start task written
  logic         abortHit;                 // abort task written
  logic         kill;                     // abort or preemption
  logic         doneSet;                  // completion this cycle
  logic         errSet;                   // error this cycle
  logic [3:0]   nidx;                     // next word index

  // ****************************************
  // next state logic
  // ****************************************
  always_comb begin
    next_state    = state;
    next_idx      = idx;
    next_memReq   = memReq;
    next_memWrite = memWrite;
    next_memAddr  = memAddr;
    next_memWdata = memWdata;
    next_aesLoad  = 1'b0;
    next_aesKey   = aesKey;
    next_aesBlock = aesBlock;
    doneSet       = 1'b0;
    errSet        = 1'b0;
    nidx          = idx + 4'h1;
    startHit = wrEn && wrAddr == aes_block_encrypt_pkg::START_OFS && wrData[0];
    abortHit = wrEn && wrAddr == aes_block_encrypt_pkg::ABORT_OFS && wrData[0];
    kill     = abortHit || aesPreempt;
    case (state)
      // waiting for the start task
      aes_block_encrypt_pkg::IDLE: begin
        if (startHit) begin
          if (aesBusy) begin
            errSet = 1'b1;
          end else begin
            next_state    = aes_block_encrypt_pkg::FETCH;
            next_idx      = 4'h0;
            next_memReq   = 1'b1;
            next_memWrite = 1'b0;
            next_memAddr  = ptr + aes_block_encrypt_pkg::KEY_OFS;
          end
        end
      end
      // reading key then cleartext
      aes_block_encrypt_pkg::FETCH: begin
        if (startHit) begin
          errSet = 1'b1;
        end
        if (memAck) begin
          if (idx < 4'h4) begin
            next_aesKey[32*idx[1:0] +: 32] = memRdata;
          end else begin
            next_aesBlock[32*idx[1:0] +: 32] = memRdata;
          end
          if (kill) begin
            next_memReq = 1'b0;
            next_state  = aes_block_encrypt_pkg::IDLE;
            errSet      = 1'b1;
          end else if (idx == aes_block_encrypt_pkg::LAST_FETCH) begin
            next_memReq  = 1'b0;
            next_aesLoad = 1'b1;
            next_state   = aes_block_encrypt_pkg::CIPHER;
          end else begin
            next_idx     = nidx;
            next_memAddr = memAddr + 32'h4;
          end
        end else if (kill) begin
          next_state = aes_block_encrypt_pkg::DRAIN;
        end
      end
      // core running
      aes_block_encrypt_pkg::CIPHER: begin
        if (startHit) begin
          errSet = 1'b1;
        end
        if (kill) begin
          next_state = aes_block_encrypt_pkg::IDLE;
          errSet     = 1'b1;
        end else if (aesDone) begin
          next_aesBlock = aesResult;
          next_state    = aes_block_encrypt_pkg::STORE;
          next_idx      = 4'h0;
          next_memReq   = 1'b1;
          next_memWrite = 1'b1;
          next_memAddr  = ptr + aes_block_encrypt_pkg::CIPHER_OFS;
          next_memWdata = aesResult[31:0];
        end
      end
      // writing ciphertext back
      aes_block_encrypt_pkg::STORE: begin
        if (startHit) begin
          errSet = 1'b1;
        end
        if (memAck) begin
          if (kill) begin
            next_memReq = 1'b0;
            next_state  = aes_block_encrypt_pkg::IDLE;
            errSet      = 1'b1;
          end else if (idx == aes_block_encrypt_pkg::LAST_STORE) begin
            next_memReq = 1'b0;
            next_state  = aes_block_encrypt_pkg::IDLE;
            doneSet     = 1'b1;
          end else begin
            next_idx      = nidx;
            next_memAddr  = memAddr + 32'h4;
            next_memWdata = aesBlock[32*nidx[1:0] +: 32];
          end
        end else if (kill) begin
          next_state = aes_block_encrypt_pkg::DRAIN;
        end
      end
      // letting the open access finish before the error
      default: begin
        if (memAck) begin
          next_memReq = 1'b0;
          next_state  = aes_block_encrypt_pkg::IDLE;
          errSet      = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // registers, events and interrupt
  // ****************************************
  always_comb begin
    next_ptr     = ptr;
    next_doneEv  = doneEv;
    next_errorEv = errorEv;
    next_ien     = ien;
    next_rdData  = 32'h0;
    // register writes, event sets override clears
    if (wrEn) begin
      if (wrAddr == aes_block_encrypt_pkg::DONE_OFS) begin
        next_doneEv = wrData[0];
      end else if (wrAddr == aes_block_encrypt_pkg::ERROR_OFS) begin
        next_errorEv = wrData[0];
      end else if (wrAddr == aes_block_encrypt_pkg::IENSET_OFS) begin
        next_ien = ien | wrData[1:0];
      end else if (wrAddr == aes_block_encrypt_pkg::IENCLR_OFS) begin
        next_ien = ien & ~wrData[1:0];
      end else if (wrAddr == aes_block_encrypt_pkg::PTR_OFS) begin
        next_ptr = wrData;
      end
    end
    if (doneSet) begin
      next_doneEv = 1'b1;
    end
    if (errSet) begin
      next_errorEv = 1'b1;
    end
    // read answers, unmapped and task offsets read zero
    if (rdEn) begin
      if (rdAddr == aes_block_encrypt_pkg::DONE_OFS) begin
        next_rdData = {31'h0, doneEv};
      end else if (rdAddr == aes_block_encrypt_pkg::ERROR_OFS) begin
        next_rdData = {31'h0, errorEv};
      end else if (rdAddr == aes_block_encrypt_pkg::IENSET_OFS ||
                   rdAddr == aes_block_encrypt_pkg::IENCLR_OFS) begin
        next_rdData = {30'h0, ien};
      end else if (rdAddr == aes_block_encrypt_pkg::PTR_OFS) begin
        next_rdData = ptr;
      end
    end
    next_irq = (next_doneEv && next_ien[aes_block_encrypt_pkg::DONE_BIT])
      || (next_errorEv && next_ien[aes_block_encrypt_pkg::ERROR_BIT]);
  end

  // ****************************************
  // flip-flops
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state    <= aes_block_encrypt_pkg::IDLE;
      idx      <= 4'h0;
      ptr      <= aes_block_encrypt_pkg::PTR_RESET;
      doneEv   <= 1'b0;
      errorEv  <= 1'b0;
      ien      <= aes_block_encrypt_pkg::IEN_RESET;
      rdData   <= 32'h0;
      irq      <= 1'b0;
      memReq   <= 1'b0;
      memWrite <= 1'b0;
      memAddr  <= 32'h0;
      memWdata <= 32'h0;
      aesLoad  <= 1'b0;
      aesKey   <= 128'h0;
      aesBlock <= 128'h0;
    end else begin
      state    <= next_state;
      idx      <= next_idx;
      ptr      <= next_ptr;
      doneEv   <= next_doneEv;
      errorEv  <= next_errorEv;
      ien      <= next_ien;
      rdData   <= next_rdData;
      irq      <= next_irq;
      memReq   <= next_memReq;
      memWrite <= next_memWrite;
      memAddr  <= next_memAddr;
      memWdata <= next_memWdata;
      aesLoad  <= next_aesLoad;
      aesKey   <= next_aesKey;
      aesBlock <= next_aesBlock;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  int elapsed; // cycles since the running block began
  always_ff @(posedge clk) begin
    if (reset || state == aes_block_encrypt_pkg::IDLE) begin
      elapsed <= 0;
    end else begin
      elapsed <= elapsed + 1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_start;
    state == aes_block_encrypt_pkg::IDLE && startHit && !aesBusy |=>
      state == aes_block_encrypt_pkg::FETCH && memReq && !memWrite
      && memAddr == $past(ptr);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_busy;
    state == aes_block_encrypt_pkg::IDLE && startHit && aesBusy |=>
      errorEv && state == aes_block_encrypt_pkg::IDLE;
  endproperty
  a_busy: assert property (p_busy) else $error("busy start");
  property p_abort;
    state == aes_block_encrypt_pkg::CIPHER && abortHit |=>
      state == aes_block_encrypt_pkg::IDLE && errorEv && !$rose(doneEv);
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");
  property p_readev;
    rdEn && rdAddr == aes_block_encrypt_pkg::ERROR_OFS |=>
      rdData == {31'h0, $past(errorEv)};
  endproperty
  a_readev: assert property (p_readev) else $error("event read");
  property p_ienclr;
    wrEn && wrAddr == aes_block_encrypt_pkg::IENCLR_OFS && wrData[1] |=>
      !ien[1] ##1 !ien[1] || $past(wrEn);
  endproperty
  a_ienclr: assert property (p_ienclr) else $error("enable clear");
  property p_ptr;
    wrEn && wrAddr == aes_block_encrypt_pkg::PTR_OFS |=>
      ptr == $past(wrData);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write");
  property p_time;
    doneSet |-> elapsed < aes_block_encrypt_pkg::RUN_CYCLES;
  endproperty
  a_time: assert property (p_time) else $error("block too slow");
  property p_layout;
    state == aes_block_encrypt_pkg::STORE && memReq |->
      memWrite && memAddr - ptr >= 32'h20 && memAddr - ptr < 32'h30;
  endproperty
  a_layout: assert property (p_layout) else $error("store address");
  property p_quiet;
    $rose(doneEv) || $rose(errorEv) |-> !memReq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("dma still open");
  property p_irq;
    doneEv && ien[0] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  c_done:    cover property ($rose(doneEv));
  c_abort:   cover property (state == aes_block_encrypt_pkg::DRAIN);
  c_preempt: cover property (state == aes_block_encrypt_pkg::CIPHER
                             && aesPreempt);
endmodule : aes_block_encrypt_unit

// ### design/aes_block_encrypt_pkg.sv
// constants and types for the block encryption unit
package aes_block_encrypt_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] START_OFS  = 12'h000; // start task
  localparam logic [11:0] ABORT_OFS  = 12'h004; // abort task
  localparam logic [11:0] DONE_OFS   = 12'h100; // completion event
  localparam logic [11:0] ERROR_OFS  = 12'h104; // error event
  localparam logic [11:0] IENSET_OFS = 12'h304; // interrupt enable set
  localparam logic [11:0] IENCLR_OFS = 12'h308; // interrupt enable clear
  localparam logic [11:0] PTR_OFS    = 12'h504; // structure pointer

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          DONE_BIT   = 0;        // enable bit, completion
  localparam int          ERROR_BIT  = 1;        // enable bit, error
  localparam logic [31:0] PTR_RESET  = 32'h0;    // pointer after reset
  localparam logic [1:0]  IEN_RESET  = 2'h0;     // enables after reset

  // ****************************************
  // memory structure layout
  // ****************************************
  localparam logic [31:0] KEY_OFS    = 32'h00;   // key, 16 bytes
  localparam logic [31:0] CIPHER_OFS = 32'h20;   // ciphertext, 16 bytes
  localparam logic [3:0]  LAST_FETCH = 4'h7;     // key and cleartext words
  localparam logic [3:0]  LAST_STORE = 4'h3;     // ciphertext words

  // ****************************************
  // timing
  // ****************************************
  localparam int RUN_TIME_NS   = 7200;          // longest run per block
  localparam int CLK_PERIOD_NS = 40;            // 25 mhz clock
  localparam int RUN_CYCLES    = RUN_TIME_NS / CLK_PERIOD_NS; // rounds down

  // sequencer states
  typedef enum logic [2:0] {IDLE, FETCH, CIPHER, STORE, DRAIN} state_t;

endpackage : aes_block_encrypt_pkg

// ### testbench/aes_mem_model.sv
// data ram and shared aes core stand-in for the encryption unit
`timescale 1ns/1ns
module aes_mem_model #(
  parameter int CORE_LAT = 20 // core cycles per block
) (
  input  wire logic         clk,
  input  wire logic         slow,
  input  wire logic         memReq,
  input  wire logic         memWrite,
  input  wire logic [31:0]  memAddr,
  input  wire logic [31:0]  memWdata,
  output logic      [31:0]  memRdata,
  output logic              memAck,
  input  wire logic         aesLoad,
  input  wire logic [127:0] aesKey,
  input  wire logic [127:0] aesBlock,
  output logic              aesDone,
  output logic      [127:0] aesResult
);
  logic [31:0]  mem [0:63]; // word store
  logic [1:0]   waitCnt;    // cycles waited on an access
  logic [7:0]   coreCnt;    // core cycles left
  logic [127:0] res;        // result held for the done pulse

  initial begin
    memAck  = 1'b0;
    aesDone = 1'b0;
    waitCnt = 2'h0;
    coreCnt = 8'h0;
    res     = 128'h0;
  end

  // ****************************************
  // memory: one ack per access, 0 or 2 waits
  // ****************************************
  always @(posedge clk) begin
    memAck  <= memReq && !memAck && (waitCnt >= (slow ? 2'h2 : 2'h0));
    waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
    if (memReq && memAck && memWrite) begin
      mem[memAddr[7:2]] <= memWdata;
    end
  end
  // data valid only in the ack cycle, inverse otherwise
  assign memRdata = memAck ? mem[memAddr[7:2]] : ~mem[memAddr[7:2]];

  // ****************************************
  // core: xor stand-in, fixed latency
  // ****************************************
  always @(posedge clk) begin
    aesDone <= (coreCnt == 8'h1);
    if (aesLoad) begin
      coreCnt <= CORE_LAT[7:0];
      res     <= aesKey ^ aesBlock;
    end else if (coreCnt != 8'h0) begin
      coreCnt <= coreCnt - 8'h1;
    end
  end
  assign aesResult = aesDone ? res : ~res;
endmodule : aes_mem_model

// ### testbench/aes_block_encrypt_unit_test.sv
// self-checking bench for the block encryption unit
`timescale 1ns/1ns
module aes_block_encrypt_unit_test;
  logic         clk, reset, wrEn, rdEn, irq, slow, reqSeen;
  logic [11:0]  wrAddr, rdAddr;
  logic [31:0]  wrData, rdData, memAddr, memWdata, memRdata;
  logic         memReq, memWrite, memAck, aesBusy, aesPreempt;
  logic         aesLoad, aesDone;
  logic [127:0] aesKey, aesBlock, aesResult;
  int           err_total = 0;
  int           n_tests = 0;

  aes_block_encrypt_unit uut (.clk, .reset, .wrAddr, .wrData, .wrEn,
    .rdAddr, .rdEn, .rdData, .irq, .memReq, .memWrite, .memAddr,
    .memWdata, .memRdata, .memAck, .aesBusy, .aesPreempt, .aesLoad,
    .aesKey, .aesBlock, .aesDone, .aesResult);
  aes_mem_model model (.clk, .slow, .memReq, .memWrite, .memAddr,
    .memWdata, .memRdata, .memAck, .aesLoad, .aesKey, .aesBlock,
    .aesDone, .aesResult);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // notes dma requests while the core is held busy
  always @(posedge clk) begin
    reqSeen <= aesBusy && (reqSeen || memReq);
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic results();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h want %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wrAddr <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask : wr
  // read; answer sampled in the cycle after the strobe
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    rdAddr <= a;
    rdEn   <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    chk(rdData, exp);
    @(posedge clk);
  endtask : rc
  // waits for irq, counting cycles from the call, one cycle after the start write is taken
  task automatic waitIrq(output int n);
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        $display("[ERR] %0t interrupt timeout", $time);
        err_total++;
        results();
      end
    end
    @(posedge clk);
  endtask : waitIrq

  // ****************************************
  // scenarios
  // ****************************************
  task automatic tResets();
    rc(aes_block_encrypt_pkg::PTR_OFS, 32'h0);
    rc(aes_block_encrypt_pkg::IENSET_OFS, 32'h0);
    rc(aes_block_encrypt_pkg::IENCLR_OFS, 32'h0);
    rc(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
    rc(12'h200, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : tResets
  task automatic tRegs();
    wr(aes_block_encrypt_pkg::PTR_OFS, 32'h1234_5678);
    rc(aes_block_encrypt_pkg::PTR_OFS, 32'h1234_5678);
    wr(aes_block_encrypt_pkg::IENSET_OFS, 32'h3);
    rc(aes_block_encrypt_pkg::IENCLR_OFS, 32'h3);
    wr(aes_block_encrypt_pkg::IENCLR_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::IENSET_OFS, 32'h2);
    wr(aes_block_encrypt_pkg::IENSET_OFS, 32'h0);
    rc(aes_block_encrypt_pkg::IENSET_OFS, 32'h2);
    wr(aes_block_encrypt_pkg::IENCLR_OFS, 32'h2);
    rc(aes_block_encrypt_pkg::IENSET_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::IENSET_OFS, 32'h3);
  endtask : tRegs
  // full block at pointer p, fast or slow memory
  task automatic tEncrypt(input logic s, input logic [31:0] p);
    int          n;
    logic [31:0] e [4];
    logic [5:0]  b;
    b = p[7:2];
    slow <= s;
    for (int i = 0; i < 12; i++) begin
      model.mem[b + 6'(i)] = (i < 8) ? p ^ (32'h9e3779b9 * 32'(i + 1)) : 0;
    end
    for (int i = 0; i < 4; i++) begin
      e[i] = model.mem[b + 6'(i)] ^ model.mem[b + 6'(i + 4)];
    end
    wr(aes_block_encrypt_pkg::PTR_OFS, p);
    wr(aes_block_encrypt_pkg::START_OFS, 32'h1);
    waitIrq(n);
    chk(32'(n <= aes_block_encrypt_pkg::RUN_CYCLES), 32'h1);
    chk({31'h0, memReq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      chk(model.mem[b + 6'(i + 8)], e[i]);
    end
    rc(aes_block_encrypt_pkg::DONE_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : tEncrypt
  task automatic tBusy();
    aesBusy <= 1'b1;
    wr(aes_block_encrypt_pkg::START_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h1);
    chk({31'h0, reqSeen}, 32'h0);
    aesBusy <= 1'b0;
    wr(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
  endtask : tBusy
  // abort with a slow dma access open, then abort in idle
  task automatic tAbort();
    int n;
    wr(aes_block_encrypt_pkg::START_OFS, 32'h1);
    repeat (3) @(posedge clk);
    wr(aes_block_encrypt_pkg::ABORT_OFS, 32'h1);
    waitIrq(n);
    chk({31'h0, memReq}, 32'h0);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::ABORT_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
  endtask : tAbort
  // waits for the core load pulse, then one edge more
  task automatic waitLoad();
    int n;
    n = 0;
    while (aesLoad !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        $display("[ERR] %0t core load timeout", $time);
        err_total++;
        results();
      end
    end
    @(posedge clk);
  endtask : waitLoad
  // abort while the block sits in the core
  task automatic tCoreAbort();
    int n;
    wr(aes_block_encrypt_pkg::START_OFS, 32'h1);
    waitLoad();
    wr(aes_block_encrypt_pkg::ABORT_OFS, 32'h1);
    waitIrq(n);
    repeat (40) @(posedge clk);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::ERROR_OFS, 32'h0);
  endtask : tCoreAbort
  // another core user takes over while the block is in the core
  task automatic tTakeover();
    int n;
    wr(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
    wr(aes_block_encrypt_pkg::START_OFS, 32'h1);
    waitLoad();
    aesPreempt <= 1'b1;
    @(posedge clk);
    aesPreempt <= 1'b0;
    waitIrq(n);
    repeat (40) @(posedge clk);
    rc(aes_block_encrypt_pkg::ERROR_OFS, 32'h1);
    rc(aes_block_encrypt_pkg::DONE_OFS, 32'h0);
  endtask : tTakeover

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {reset, wrEn, rdEn, slow, aesBusy, aesPreempt} = 6'h20;
    wrAddr = 12'h0;
    rdAddr = 12'h0;
    wrData = 32'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    tResets();
    tRegs();
    tEncrypt(1'b0, 32'h0000_0040);
    tEncrypt(1'b1, 32'h0000_0080);
    tBusy();
    tAbort();
    tCoreAbort();
    tTakeover();
    results();
  end
endmodule : aes_block_encrypt_unit_test
